/* File: rtl/chroma_hue_pkg.sv */
// constants for the chroma gain, hue and field loop control registers
package chroma_hue_pkg;
	localparam logic [11:0] chroma_v_gain_low_off = 12'h038;
	localparam logic [11:0] hue_phase_offset_off = 12'h03C;
	localparam logic [11:0] even_field_loop_control_off = 12'h040;
	localparam logic [11:0] odd_field_loop_control_off = 12'h0C0;
	localparam logic [11:0] control_bits_off = 12'h100;
	localparam logic [11:0] scale_ratio_off = 12'h104;
	localparam logic [7:0] chroma_v_gain_low_rst = 8'hB4;
	localparam logic [7:0] hue_phase_offset_rst = 8'h00;
	localparam logic [7:0] loop_control_rst = 8'h00;
	localparam logic [1:0] control_bits_rst = 2'h2;
	localparam logic [7:0] scale_ratio_rst = 8'h00;
	localparam int peak_bit = 7;
	localparam int chroma_auto_gain_enable_bit = 6;
	localparam int low_colour_removal_enable_bit = 5;
	localparam int horizontal_filter_select_lo = 3;
	localparam int luma_decimation_disable_bit = 1;
	localparam int v_top_bit = 0;
	localparam logic [8:0] v_gain_unity = 9'h0B4;
	localparam logic [7:0] hue_step_centideg = 8'h46;
	localparam logic [7:0] scale_half = 8'h80;
	localparam logic [7:0] scale_quarter = 8'h40;
	localparam logic [7:0] scale_eighth = 8'h20;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef enum logic [1:0] {
		filt_none = 2'h0,
		filt_cif = 2'h1,
		filt_qcif = 2'h2,
		filt_icon = 2'h3
	} filter_sel_t;
	typedef enum logic [1:0] {
		peak_off = 2'h0,
		peak_min = 2'h1,
		peak_med = 2'h2,
		peak_max = 2'h3
	} peak_sel_t;
	typedef enum logic [1:0] {
		wr_idle = 2'h0,
		wr_resp = 2'h1
	} wr_state_t;
endpackage : chroma_hue_pkg

/* File: rtl/chroma_hue_filter_control.sv */
// register bank for v gain, hue offset and per-field loop control
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - v gain low byte at 0x038, read/write, resets to 0xB4
// - nine-bit v gain is top bit above the low byte
// - v component scaled by gain, 0x0B4 means unity
// - hue at 0x03C, resets zero, two's complement subcarrier phase offset
// - 256 hue steps of 0.7 degrees, zero leaves hue unchanged
// - even loop control 0x040, odd 0x0C0, each used in own field
// - bit 7 picks peaking filters instead of low-pass filters
// - bit 6 enables chroma automatic gain control
// - bit 5 enables low-colour detection and removal
// - bits 4:3 pick cif, qcif or icon low-pass filter
// - code 00 picks filter automatically from horizontal scale ratio
// - with peaking, bits 4:3 pick minimum, medium or maximum peaking
// - decimation disable bit zero enables decimation, one disables it
// - control bit 0 holds v gain top bit
module chroma_hue_filter_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic odd_field,
	input wire logic [8:0] v_in,
	output logic [17:0] v_scaled,
	output logic [8:0] chroma_v_gain,
	output logic [7:0] hue_phase,
	output logic peak_enable,
	output chroma_hue_pkg::peak_sel_t peak_strength,
	output logic chroma_auto_gain_enable,
	output logic low_colour_removal_enable,
	output chroma_hue_pkg::filter_sel_t horizontal_filter_select,
	output logic luma_decimation_disable
);
	import chroma_hue_pkg::*;

	logic [7:0] v_low_r;
	logic [7:0] hue_r;
	logic [7:0] even_loop_r;
	logic [7:0] odd_loop_r;
	logic [1:0] ctrl_r;
	logic [7:0] scale_r;
	logic [11:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic w_strb0_r;
	logic w_have_r;
	wr_state_t wr_state_r;

	// map a word address to its 8-bit read value, with a hit flag
	function automatic logic [8:0] read_word(
		input logic [11:0] a,
		input logic [7:0] vl,
		input logic [7:0] hu,
		input logic [7:0] ev,
		input logic [7:0] od,
		input logic [1:0] ct,
		input logic [7:0] sc
	);
		logic [8:0] r;
		r = 9'h000;
		case (a)
			chroma_v_gain_low_off: r = {1'b1, vl};
			hue_phase_offset_off: r = {1'b1, hu};
			even_field_loop_control_off: r = {1'b1, ev};
			odd_field_loop_control_off: r = {1'b1, od};
			control_bits_off: r = {1'b1, 6'h00, ct};
			scale_ratio_off: r = {1'b1, sc};
			default: r = 9'h000;
		endcase
		return r;
	endfunction : read_word

	// write channel: address and data accepted in either order
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire have_aw = aw_have_r | aw_take;
	wire have_w = w_have_r | w_take;
	wire [11:0] wa = aw_have_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wd = w_have_r ? w_data_r : s_axi_wdata;
	wire ws0 = w_have_r ? w_strb0_r : s_axi_wstrb[0];
	// a write waits until both halves are in hand
	wire do_write = (wr_state_r == wr_idle) & have_aw & have_w;
	wire wr_lane = do_write & ws0;
	wire [11:0] wa_word = {wa[11:2], 2'h0};
	// same decoder as the read side, reused for the response code
	wire [8:0] wr_hit = read_word(wa_word, v_low_r, hue_r, even_loop_r,
		odd_loop_r, ctrl_r, scale_r);
	wire wr_v = wr_lane & (wa_word == chroma_v_gain_low_off);
	wire wr_hue = wr_lane & (wa_word == hue_phase_offset_off);
	wire wr_even = wr_lane & (wa_word == even_field_loop_control_off);
	wire wr_odd = wr_lane & (wa_word == odd_field_loop_control_off);
	wire wr_ctrl = wr_lane & (wa_word == control_bits_off);
	wire wr_scale = wr_lane & (wa_word == scale_ratio_off);

	// read channel: one outstanding read, answered one cycle after the address is accepted
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [8:0] rd_hit = read_word({s_axi_araddr[11:2], 2'h0}, v_low_r,
		hue_r, even_loop_r, odd_loop_r, ctrl_r, scale_r);

	// field selects its own loop control word
	wire [7:0] loop_sel = odd_field ? odd_loop_r : even_loop_r;
	wire peak_sel = loop_sel[peak_bit];
	wire [1:0] hf_code = loop_sel[horizontal_filter_select_lo+1:horizontal_filter_select_lo];
	wire [8:0] gain_sel = {ctrl_r[v_top_bit], v_low_r};
	// auto pick from ratio of output to input width, 0x80 = one half
	wire [1:0] auto_filt = (scale_r >= scale_half) ? filt_none :
		(scale_r >= scale_quarter) ? filt_cif :
		(scale_r >= scale_eighth) ? filt_qcif : filt_icon;
	wire [1:0] lp_code = (hf_code == 2'h0) ? auto_filt : hf_code;
	// decimation disabled or peaking on means no low-pass filter runs
	wire [1:0] filt_nxt = (peak_sel | ctrl_r[luma_decimation_disable_bit]) ? filt_none :
		lp_code;
	wire [1:0] peak_nxt = peak_sel ? hf_code : peak_off;
	// full-scale product kept; datapath divides by unity code itself
	wire [17:0] v_prod = v_in * gain_sel;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			v_low_r <= chroma_v_gain_low_rst;
		end else if (wr_v) begin
			v_low_r <= wd[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hue_r <= hue_phase_offset_rst;
		end else if (wr_hue) begin
			hue_r <= wd[7:0];
		end
	end

	// reserved bits 2:0 kept as written; software keeps them zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			even_loop_r <= loop_control_rst;
		end else if (wr_even) begin
			even_loop_r <= wd[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			odd_loop_r <= loop_control_rst;
		end else if (wr_odd) begin
			odd_loop_r <= wd[7:0];
		end
	end

	// bit 0 is the gain top bit, bit 1 the decimation disable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= control_bits_rst;
		end else if (wr_ctrl) begin
			ctrl_r <= wd[1:0];
		end
	end

	// ratio only steers the automatic filter pick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scale_r <= scale_ratio_rst;
		end else if (wr_scale) begin
			scale_r <= wd[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h0000_0000;
			w_strb0_r <= 1'b0;
			wr_state_r <= wr_idle;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			if (aw_take) aw_addr_r <= s_axi_awaddr;
			if (w_take) w_data_r <= s_axi_wdata;
			if (w_take) w_strb0_r <= s_axi_wstrb[0];
			// readies stay low until the response is taken: one write in flight
			case (wr_state_r)
				wr_idle: begin
					if (do_write) begin
						wr_state_r <= wr_resp;
						aw_have_r <= 1'b0;
						w_have_r <= 1'b0;
						s_axi_awready <= 1'b0;
						s_axi_wready <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wr_hit[8] ? resp_okay : resp_slverr;
					end else begin
						aw_have_r <= have_aw;
						w_have_r <= have_w;
						s_axi_awready <= ~have_aw;
						s_axi_wready <= ~have_w;
					end
				end
				wr_resp: begin
					if (s_axi_bready) begin
						wr_state_r <= wr_idle;
						s_axi_bvalid <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
					end
				end
				default: wr_state_r <= wr_idle;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (ar_take) begin
			// data captured at acceptance, so a later write cannot tear it
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_hit[7:0]};
			s_axi_rresp <= rd_hit[8] ? resp_okay : resp_slverr;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// controls registered so every output leaves a flip-flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			v_scaled <= 18'h00000;
			chroma_v_gain <= v_gain_unity;
		end else begin
			v_scaled <= v_prod;
			chroma_v_gain <= gain_sel;
		end
	end

	// signed 0.7 degree steps, datapath adds to subcarrier phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hue_phase <= hue_phase_offset_rst;
		end else begin
			hue_phase <= hue_r;
		end
	end

	// loop bits follow the field input one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			peak_enable <= 1'b0;
			peak_strength <= peak_off;
			chroma_auto_gain_enable <= 1'b0;
			low_colour_removal_enable <= 1'b0;
		end else begin
			peak_enable <= peak_sel;
			peak_strength <= peak_sel_t'(peak_nxt);
			chroma_auto_gain_enable <= loop_sel[chroma_auto_gain_enable_bit];
			low_colour_removal_enable <= loop_sel[low_colour_removal_enable_bit];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			horizontal_filter_select <= filt_none;
			luma_decimation_disable <= 1'b1;
		end else begin
			horizontal_filter_select <= filter_sel_t'(filt_nxt);
			luma_decimation_disable <= ctrl_r[luma_decimation_disable_bit];
		end
	end
endmodule : chroma_hue_filter_control
`default_nettype wire

/* File: verif/chroma_hue_sva.sv */
// assertion checker for the chroma gain, hue and loop control bank
`timescale 1ns/1ns
`default_nettype none
module chroma_hue_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [8:0] v_in,
	input wire logic [17:0] v_scaled,
	input wire logic [8:0] chroma_v_gain,
	input wire logic peak_enable,
	input wire chroma_hue_pkg::peak_sel_t peak_strength,
	input wire chroma_hue_pkg::filter_sel_t horizontal_filter_select,
	input wire logic luma_decimation_disable
);
	import chroma_hue_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_b_held: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
	chk_aw_blocked: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
	chk_r_held: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("r lost");
	chk_r_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("r upper");
	chk_v_product: assert property (
		$past(aresetn) && $stable(chroma_v_gain) |->
		v_scaled == 18'($past(v_in)) * 18'(chroma_v_gain)) else $error("v mul");
	chk_gain_reset: assert property (
		$rose(aresetn) |-> chroma_v_gain == v_gain_unity) else $error("gain rst");
	chk_peak_off: assert property (
		!peak_enable |-> peak_strength == peak_off) else $error("strength");
	chk_filter_idle: assert property (
		peak_enable || luma_decimation_disable |->
		horizontal_filter_select == filt_none) else $error("filter");
endmodule : chroma_hue_sva
bind chroma_hue_filter_control chroma_hue_sva i_sva (.aclk, .aresetn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .v_in, .v_scaled, .chroma_v_gain,
	.peak_enable, .peak_strength, .horizontal_filter_select,
	.luma_decimation_disable);
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the chroma gain, hue and loop control bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((x) !== (g)) begin \
	err_total++; $display("mismatch %s exp %0h got %0h", n, x, g); end end
module tb_top;
	import chroma_hue_pkg::*;
	logic aclk = 0, aresetn = 0, odd_field = 0, s_axi_awvalid = 0;
	logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [8:0] v_in = 0, chroma_v_gain;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, peak_enable, chroma_auto_gain_enable;
	logic low_colour_removal_enable, luma_decimation_disable;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [17:0] v_scaled;
	logic [7:0] hue_phase, d;
	logic [33:0] bq[$], rq[$], e;
	peak_sel_t peak_strength;
	filter_sel_t horizontal_filter_select;
	int err_total = 0, total_checks = 0;
	logic [11:0] offs [4] = '{12'h038, 12'h03C, 12'h040, 12'h0C0};
	logic [7:0] ratio [4] = '{8'hC0, 8'h40, 8'h3F, 8'h1F};
	filter_sel_t fexp [4] = '{filt_none, filt_cif, filt_qcif, filt_icon};
	always #4 aclk = ~aclk;
	chroma_hue_filter_control i_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .odd_field,
		.v_in, .v_scaled, .chroma_v_gain, .hue_phase, .peak_enable,
		.peak_strength, .chroma_auto_gain_enable, .low_colour_removal_enable,
		.horizontal_filter_select, .luma_decimation_disable);
	// responses are checked where they appear, in issue order
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			e = bq.pop_front();
			`CHK("bresp", e, {32'h0, s_axi_bresp})
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			`CHK("rdata", e, {s_axi_rresp, s_axi_rdata})
		end
	end
	// ready is raised late so the slave must hold its response
	task automatic wr(input logic [11:0] a, input logic [7:0] v,
		input logic [3:0] s, input logic [1:0] r);
		int n = 0;
		bq.push_back({32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			s_axi_bready <= n > 0;
			n++;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] v,
		input logic [1:0] r);
		int n = 0;
		rq.push_back({r, 24'h0, v});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			s_axi_rready <= n > 0;
			n++;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic outs(input logic p, c, k, input logic [1:0] s, f);
		repeat (3) @(posedge aclk);
		`CHK("peak", p, peak_enable)
		`CHK("strength", s, peak_strength)
		`CHK("agc", c, chroma_auto_gain_enable)
		`CHK("kill", k, low_colour_removal_enable)
		`CHK("filter", f, horizontal_filter_select)
	endtask : outs
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3000) @(posedge aclk);
		err_total++;
		wrap_up();
	end
	initial begin
		void'($urandom(99653));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			rd(offs[i], i ? 8'h00 : 8'hB4, resp_okay);
		end
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom) & ((i > 1) ? 8'hF8 : 8'hFF);
			wr(offs[i], d, 4'hF, resp_okay);
			rd(offs[i], d, resp_okay);
		end
		wr(offs[3], 8'h58, 4'h0, resp_okay);
		rd(offs[3], d, resp_okay);
		wr(12'h044, 8'hFF, 4'hF, resp_slverr);
		rd(12'h044, 8'h00, resp_slverr);
		wr(control_bits_off, 8'h01, 4'hF, resp_okay);
		wr(offs[0], 8'h34, 4'hF, resp_okay);
		wr(offs[1], 8'h80, 4'hF, resp_okay);
		v_in <= 9'($urandom);
		repeat (3) @(posedge aclk);
		`CHK("gain", 9'h134, chroma_v_gain)
		`CHK("vscaled", 18'(v_in) * 18'h134, v_scaled)
		`CHK("hue", 8'h80, hue_phase)
		wr(offs[2], 8'hE8, 4'hF, resp_okay);
		wr(offs[3], 8'h58, 4'hF, resp_okay);
		outs(1, 1, 1, 2'h1, filt_none);
		odd_field <= 1'b1;
		outs(0, 1, 0, 2'h0, filt_icon);
		wr(offs[3], 8'h00, 4'hF, resp_okay);
		for (int i = 0; i < 4; i++) begin
			wr(scale_ratio_off, ratio[i], 4'hF, resp_okay);
			outs(0, 0, 0, 2'h0, fexp[i]);
		end
		wr(control_bits_off, 8'h02, 4'hF, resp_okay);
		outs(0, 0, 0, 2'h0, filt_none);
		`CHK("luma_decimation_disable", 1'b1, luma_decimation_disable)
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
